//--- rtl/lpd_pkg.sv
// Purpose: shared constants of the second loop configuration block
// Assumes: byte-wide register port, one reference clock
// Notes: offsets, field positions and reset values live only here
package lpd_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PDIV = 8'h26;  // output post-divider
    localparam logic [7:0] OFF_SETA = 8'h2B;  // set a band select
    localparam logic [7:0] OFF_FBH = 8'h2C;   // set b feedback high
    localparam logic [7:0] OFF_FBL = 8'h2D;   // feedback low, remainder high
    localparam logic [7:0] OFF_RMQ = 8'h2E;   // remainder low, quotient high
    localparam logic [7:0] OFF_QSB = 8'h2F;   // quotient low, shift, band
    localparam logic [7:0] OFF_XCAP = 8'h30;  // crystal load capacitance

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [6:0] RST_PDIV = 7'h01;
    localparam logic [1:0] RST_SETA = 2'h0;
    localparam logic [7:0] RST_FBH = 8'h00;
    localparam logic [7:0] RST_FBL = 8'h40;
    localparam logic [7:0] RST_RMQ = 8'h02;
    localparam logic [7:0] RST_QSB = 8'h08;
    localparam logic [4:0] RST_XCAP = 5'h00;

    // ------------------------------------------------------------
    // field positions inside the byte registers
    // ------------------------------------------------------------
    localparam int FBL_FB_LSB = 4;   // feedback [3:0] at 2D[7:4]
    localparam int RMQ_RM_LSB = 3;   // remainder [4:0] at 2E[7:3]
    localparam int QSB_Q_LSB = 5;    // quotient [2:0] at 2F[7:5]
    localparam int QSB_SH_LSB = 2;   // shift at 2F[4:2]

    // ------------------------------------------------------------
    // band codes and limits
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LPD_BAND_LOW = 2'b00,   // below 125 MHz
        LPD_BAND_MID = 2'b01,   // 125 up to 150 MHz
        LPD_BAND_HIGH = 2'b10,  // 150 up to 175 MHz
        LPD_BAND_TOP = 2'b11    // 175 MHz and above
    } lpd_band_t;

    localparam logic [7:0] XCAP_MAX_PF = 8'h14;  // 20 pF ceiling, 1 pF per step
    localparam int SYNC_STAGES = 3;              // pin synchroniser depth

endpackage

//--- rtl/lpd_div_if.sv
// Purpose: carrier between configuration core and post-divider
// Assumes: both ends on clk_i
// Notes: run low holds the divider in reset
`timescale 1ns/1ps
interface lpd_div_if;
    logic [6:0] pdiv;  // divide value, zero means standby
    logic run;         // device powered and enabled
    logic tick;        // one pulse per divided period

    modport ctrl (output pdiv, output run, input tick);
    modport div (input pdiv, input run, output tick);
endinterface

//--- rtl/lpd_postdiv.sv
// Purpose: output post-divider producing a divided-rate pulse
// Assumes: pdiv changes are rare; a change restarts the count
// Notes: pdiv of one gives a pulse every cycle
`timescale 1ns/1ps
module lpd_postdiv
    import lpd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // configuration core side
    lpd_div_if.div dv
);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [6:0] cnt;           // position in the divided period
    logic [6:0] last_pdiv;     // value the count was started with
    logic hold;                // standby, power-down or a pdiv change
    logic wrap;                // period complete
    logic [6:0] next_cnt;

    assign hold = !dv.run || (dv.pdiv == 7'h00) || (dv.pdiv != last_pdiv);
    assign wrap = (cnt == dv.pdiv - 7'h01);
    assign next_cnt = wrap ? 7'h00 : cnt + 7'h01;

    // count and pulse; a held divider emits nothing
    // zero means standby
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 7'h00;
            last_pdiv <= 7'h00;
            dv.tick <= 1'b0;
        end else if (hold) begin
            cnt <= 7'h00;
            last_pdiv <= dv.pdiv;
            dv.tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            dv.tick <= wrap;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_pdiv_zero;
        @(posedge clk_i) disable iff (!nrst_i)
        (dv.pdiv == 7'h00) |=> !dv.tick;
    endproperty
    a_pdiv_zero: assert property (p_pdiv_zero) else $error("tick while pdiv zero");

    // two more running cycles after a tick; a pdiv change in between restarts the count
    sequence s_div3_run;
        (!hold && dv.pdiv == 7'h03) [*2];
    endsequence
    property p_div3;
        @(posedge clk_i) disable iff (!nrst_i)
        (dv.tick && !hold && dv.pdiv == 7'h03) ##1 s_div3_run
            |=> dv.tick && !$past(dv.tick);
    endproperty
    a_div3: assert property (p_div3) else $error("divide by three period wrong");

endmodule

//--- rtl/lpd_loop2_cfg.sv
// Purpose: second loop configuration registers, power-up gating, post-divider
// Assumes: register port and nonvolatile loader share clk_i
// Notes: stored fields drive the fractional divider as written
//
// Notes on behaviour
// - band code picks oscillator frequency band
// - output is input times N over M, divided
// - post-divider divides by 1 to 127
// - outputs off until core supply good
// - load capacitance 0 to 20 pF steps
// - post-divider zero holds standby
`timescale 1ns/1ps
module lpd_loop2_cfg
    import lpd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // nonvolatile loader
    input wire logic nv_load_i,
    input wire logic [7:0] nv_addr_i,
    input wire logic [7:0] nv_data_i,
    // pins
    input wire logic core_supply_ok_i,
    input wire logic output_supply_i,
    input wire logic freq_sel_i,
    // power state
    output logic device_enable_o,
    output logic out_enable_o,
    // loop settings
    output logic [1:0] loop2_band_o,
    output logic [11:0] loop2_setb_feedback_o,
    output logic [8:0] loop2_setb_remainder_o,
    output logic [5:0] loop2_setb_quotient_o,
    output logic [2:0] loop2_setb_shift_o,
    // crystal and divided output
    output logic [4:0] xtal_load_pf_o,
    output logic div_tick_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int NPIN = 3;
    logic [NPIN-1:0] pin_raw;             // core ok, output supply, set select
    logic [NPIN-1:0] pin_f;               // filtered level
    assign pin_raw = {freq_sel_i, output_supply_i, core_supply_ok_i};

    // stage 1 feeds stage 2 only; level moves when 2 and 3 agree
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            logic [SYNC_STAGES-1:0] sh;   // shift chain
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    sh <= '0;
                    pin_f[gi] <= 1'b0;
                end else begin
                    sh <= {sh[SYNC_STAGES-2:0], pin_raw[gi]};
                    if (sh[1] == sh[2]) begin
                        pin_f[gi] <= sh[2];
                    end
                end
            end
        end
    endgenerate

    logic core_ok;    // core supply good
    logic outs_ok;    // output supply present
    logic sel_b;      // frequency set b selected
    assign core_ok = pin_f[0];
    assign outs_ok = pin_f[1];
    assign sel_b = pin_f[2];

    // ------------------------------------------------------------
    // write path
    // ------------------------------------------------------------
    // host write wins over a concurrent nonvolatile load
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    assign wr_en = reg_wr_i || nv_load_i;
    assign wr_addr = reg_wr_i ? reg_addr_i : nv_addr_i;
    assign wr_data = reg_wr_i ? reg_wdata_i : nv_data_i;

    logic [6:0] r_pdiv;   // output post-divider
    logic [1:0] r_seta;   // set a band
    logic [7:0] r_fbh;
    logic [7:0] r_fbl;
    logic [7:0] r_rmq;
    logic [7:0] r_qsb;
    logic [4:0] r_xcap;   // load capacitance in pF
    // carrier to the post-divider, declared ahead of its first reader
    lpd_div_if dvc ();

    logic [4:0] xcap_in;
    assign xcap_in = (wr_data > XCAP_MAX_PF) ? XCAP_MAX_PF[4:0] : wr_data[4:0];

    // register file; only the addressed byte changes
    // post-divider, band, loop word and load capacitance bytes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_pdiv <= RST_PDIV;
            r_seta <= RST_SETA;
            r_fbh <= RST_FBH;
            r_fbl <= RST_FBL;
            r_rmq <= RST_RMQ;
            r_qsb <= RST_QSB;
            r_xcap <= RST_XCAP;
        end else if (wr_en) begin
            if (wr_addr == OFF_PDIV) r_pdiv <= wr_data[6:0];
            if (wr_addr == OFF_SETA) r_seta <= wr_data[1:0];
            if (wr_addr == OFF_FBH) r_fbh <= wr_data;
            if (wr_addr == OFF_FBL) r_fbl <= wr_data;
            if (wr_addr == OFF_RMQ) r_rmq <= wr_data;
            if (wr_addr == OFF_QSB) r_qsb <= wr_data;
            if (wr_addr == OFF_XCAP) r_xcap <= xcap_in;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped offsets and unused bits read as zero
    logic [7:0] next_rdata;
    assign next_rdata =
        (reg_addr_i == OFF_PDIV) ? {1'b0, r_pdiv} :
        (reg_addr_i == OFF_SETA) ? {6'h00, r_seta} :
        (reg_addr_i == OFF_FBH) ? r_fbh :
        (reg_addr_i == OFF_FBL) ? r_fbl :
        (reg_addr_i == OFF_RMQ) ? r_rmq :
        (reg_addr_i == OFF_QSB) ? r_qsb :
        (reg_addr_i == OFF_XCAP) ? {3'h0, r_xcap} : 8'h00;

    // read data holds until the next read strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // field unpacking and outputs
    // ------------------------------------------------------------
    // fields cross byte boundaries
    logic [11:0] next_fb;
    logic [8:0] next_rm;
    logic [5:0] next_q;
    logic [2:0] next_sh;
    logic [1:0] next_band;
    assign next_fb = {r_fbh, r_fbl[7:FBL_FB_LSB]};
    assign next_rm = {r_fbl[3:0], r_rmq[7:RMQ_RM_LSB]};
    assign next_q = {r_rmq[2:0], r_qsb[7:QSB_Q_LSB]};
    assign next_sh = r_qsb[QSB_SH_LSB+2:QSB_SH_LSB];
    assign next_band = sel_b ? r_qsb[1:0] : r_seta;

    // device enable follows the core supply; out enable also needs the output supply
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            loop2_band_o <= LPD_BAND_LOW;
            loop2_setb_feedback_o <= 12'h000;
            loop2_setb_remainder_o <= 9'h000;
            loop2_setb_quotient_o <= 6'h00;
            loop2_setb_shift_o <= 3'h0;
            xtal_load_pf_o <= 5'h00;
            device_enable_o <= 1'b0;
            out_enable_o <= 1'b0;
            div_tick_o <= 1'b0;
        end else begin
            loop2_band_o <= next_band;
            loop2_setb_feedback_o <= next_fb;
            loop2_setb_remainder_o <= next_rm;
            loop2_setb_quotient_o <= next_q;
            loop2_setb_shift_o <= next_sh;
            xtal_load_pf_o <= r_xcap;
            device_enable_o <= core_ok;
            out_enable_o <= core_ok && outs_ok;
            div_tick_o <= dvc.tick;
        end
    end

    // ------------------------------------------------------------
    // post-divider
    // ------------------------------------------------------------
    // final output rate set here
    assign dvc.pdiv = r_pdiv;
    assign dvc.run = core_ok;

    lpd_postdiv u_postdiv (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .dv(dvc.div)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_wr_seta;
        (wr_en && wr_addr == OFF_SETA) ##1 !sel_b;
    endsequence
    property p_band_a;
        @(posedge clk_i) disable iff (!nrst_i)
        s_wr_seta |=> loop2_band_o == $past(wr_data[1:0], 2);
    endproperty
    a_band_a: assert property (p_band_a) else $error("set a band not applied");

    property p_feedback;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_en && wr_addr == OFF_FBH) |-> ##2 loop2_setb_feedback_o[11:4] == $past(wr_data, 2);
    endproperty
    a_feedback: assert property (p_feedback) else $error("feedback high not packed");

    property p_apply;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_en && wr_addr == OFF_QSB) |-> ##2
            (loop2_setb_shift_o == $past(wr_data[4:2], 2)
             && loop2_setb_quotient_o[2:0] == $past(wr_data[7:5], 2));
    endproperty
    a_apply: assert property (p_apply) else $error("shift or quotient altered");

    property p_xcap;
        @(posedge clk_i) disable iff (!nrst_i)
        (wr_en && wr_addr == OFF_XCAP && wr_data > XCAP_MAX_PF)
            |-> ##2 xtal_load_pf_o == XCAP_MAX_PF[4:0];
    endproperty
    a_xcap: assert property (p_xcap) else $error("load capacitance not clamped");

    property p_pwr_off;
        @(posedge clk_i) disable iff (!nrst_i)
        !core_ok |=> (!device_enable_o && !out_enable_o);
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("enabled without core supply");

    property p_out_order;
        @(posedge clk_i) disable iff (!nrst_i)
        out_enable_o |-> device_enable_o && $past(core_ok);
    endproperty
    a_out_order: assert property (p_out_order) else $error("outputs on before core");

    property p_no_tick_off;
        @(posedge clk_i) disable iff (!nrst_i)
        !device_enable_o [*2] |-> !div_tick_o;
    endproperty
    a_no_tick_off: assert property (p_no_tick_off) else $error("divider ran while off");

    property p_unmapped;
        @(posedge clk_i) disable iff (!nrst_i)
        (reg_rd_i && reg_addr_i == 8'h00) |=> reg_rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule

//--- tb/test_pll_divider_config.sv
// Purpose: self-checking bench for the second loop configuration block
// Assumes: register port strobes driven at falling edge, pins settle in 8 cycles
// Notes: a byte model keyed by offset predicts every read and field output
`timescale 1ns/1ps
module test_pll_divider_config;
    import lpd_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_i, nrst_i, reg_wr_i, reg_rd_i, nv_load_i;
    logic [7:0] reg_addr_i, reg_wdata_i, nv_addr_i, nv_data_i, reg_rdata_o;
    logic core_supply_ok_i, output_supply_i, freq_sel_i;
    logic device_enable_o, out_enable_o, div_tick_o;
    logic [1:0] band_o;
    logic [11:0] fb_o;
    logic [8:0] rm_o;
    logic [5:0] q_o;
    logic [2:0] sh_o;
    logic [4:0] xcap_o;
    int err_count = 0;
    int check_count = 0;
    int mdl [int];  // expected register bytes by offset
    lpd_loop2_cfg dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .nv_load_i(nv_load_i), .nv_addr_i(nv_addr_i),
        .nv_data_i(nv_data_i), .core_supply_ok_i(core_supply_ok_i),
        .output_supply_i(output_supply_i), .freq_sel_i(freq_sel_i),
        .device_enable_o(device_enable_o), .out_enable_o(out_enable_o),
        .loop2_band_o(band_o), .loop2_setb_feedback_o(fb_o),
        .loop2_setb_remainder_o(rm_o), .loop2_setb_quotient_o(q_o),
        .loop2_setb_shift_o(sh_o), .xtal_load_pf_o(xcap_o), .div_tick_o(div_tick_o));
    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end
    // a hang counts as a mismatch and ends the run
    initial begin
        repeat (50000) @(posedge clk_i);
        err_count++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------
    task automatic cmp(input string n, input logic [11:0] e, input logic [11:0] s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp_ticks(input int e, input int s);
        check_count++;
        if (s != e) begin
            err_count++;
            $display("unexpected tick count expected %0d seen %0d", e, s);
        end
    endtask
    // model of the byte store; masks and clamp follow the register table
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit nv);
        if (nv) begin
            {nv_load_i, nv_addr_i, nv_data_i} = {1'b1, a, d};
        end else begin
            {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        end
        @(negedge clk_i);
        reg_wr_i = 0;
        nv_load_i = 0;
        // idle edge, so a following request never re-raises a strobe in this step
        @(negedge clk_i);
        if (mdl.exists(a)) begin
            mdl[a] = (a == OFF_PDIV) ? d & 8'h7F : (a == OFF_SETA) ? d & 8'h03 :
                (a == OFF_XCAP) ? ((d > 20) ? 20 : d) : d;
        end
    endtask
    task automatic check_reg(input logic [7:0] a);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(negedge clk_i);
        reg_rd_i = 0;
        cmp($sformatf("read %h", a), 12'(mdl.exists(a) ? mdl[a] : 0), {4'h0, reg_rdata_o});
        @(negedge clk_i);
    endtask
    // fields are settled one edge after the register takes the byte
    task automatic check_fields();
        logic [7:0] c, d, e, f, s;
        @(negedge clk_i);
        {c, d, e, f, s} = {8'(mdl[OFF_FBH]), 8'(mdl[OFF_FBL]), 8'(mdl[OFF_RMQ]),
            8'(mdl[OFF_QSB]), 8'(mdl[OFF_SETA])};
        cmp("feedback", {c, d[7:4]}, fb_o);
        cmp("remainder", {3'h0, d[3:0], e[7:3]}, {3'h0, rm_o});
        cmp("quotient", {6'h0, e[2:0], f[7:5]}, {6'h0, q_o});
        cmp("shift", {9'h0, f[4:2]}, {9'h0, sh_o});
        cmp("band", {10'h0, freq_sel_i ? f[1:0] : s[1:0]}, {10'h0, band_o});
        cmp("xtal load", 12'(mdl[OFF_XCAP]), {7'h0, xcap_o});
    endtask
    // software side: a legal ratio N over M turned into stored fields
    localparam int FIN_MHZ = 27;  // assumed reference, only used to pick the band
    task automatic prog_ratio(input bit nv);
        int m, n, k, p, q, r, band;
        // ratio 3 to 8 keeps oscillator in range
        m = 1 + $urandom % 100;
        n = 3 * m + $urandom % (5 * m);
        k = 0;
        for (int j = 1; j < 12; j++) begin
            if ((m << j) <= n) k = j;
        end
        p = (k > 4) ? 0 : 4 - k;
        q = (n << p) / m;
        r = (n << p) - m * q;
        band = (FIN_MHZ * n < 125 * m) ? 0 : (FIN_MHZ * n < 150 * m) ? 1 :
            (FIN_MHZ * n < 175 * m) ? 2 : 3;
        wr(OFF_FBH, 8'(n >> 4), nv);
        wr(OFF_FBL, {n[3:0], r[8:5]}, nv);
        wr(OFF_RMQ, {r[4:0], q[5:3]}, nv);
        wr(OFF_QSB, {q[2:0], p[2:0], band[1:0]}, nv);
        check_fields();
        cmp("ratio feedback", 12'(n), fb_o);
        cmp("ratio remainder", 12'(r), {3'h0, rm_o});
        cmp("ratio quotient", 12'(q), {6'h0, q_o});
        cmp("ratio shift", 12'(p), {9'h0, sh_o});
    endtask
    task automatic do_reset();
        nrst_i = 0;
        repeat (2) @(negedge clk_i);
        nrst_i = 1;
        mdl.delete();
        mdl[OFF_PDIV] = RST_PDIV;
        mdl[OFF_SETA] = RST_SETA;
        mdl[OFF_FBH] = RST_FBH;
        mdl[OFF_FBL] = RST_FBL;
        mdl[OFF_RMQ] = RST_RMQ;
        mdl[OFF_QSB] = RST_QSB;
        mdl[OFF_XCAP] = RST_XCAP;
    endtask
    task automatic pins(input logic core, input logic outs, input logic sel);
        {core_supply_ok_i, output_supply_i, freq_sel_i} = {core, outs, sel};
        repeat (8) @(negedge clk_i);
        cmp("device enable", {11'h0, core}, {11'h0, device_enable_o});
        cmp("out enable", {11'h0, core & outs}, {11'h0, out_enable_o});
    endtask
    task automatic ticks(input logic [7:0] p, input int cyc, input int e);
        int n;
        n = 0;
        wr(OFF_PDIV, p, 0);
        repeat (4) @(negedge clk_i);
        repeat (cyc) begin
            @(negedge clk_i);
            if (div_tick_o === 1'b1) n++;
        end
        cmp_ticks(e, n);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reg_wr_i, reg_rd_i, nv_load_i, reg_addr_i, reg_wdata_i} = '0;
        {nv_addr_i, nv_data_i} = '0;
        {core_supply_ok_i, output_supply_i, freq_sel_i} = 3'b110;
        void'($urandom(6));
        do_reset();
        // reset values and the unmapped offsets 25, 27 to 2A and 31
        for (int a = 8'h25; a <= 8'h31; a++) check_reg(8'(a));
        check_fields();
        $display("test reset values done");
        // every band code on both sets, checked at the band output
        for (int i = 0; i < 4; i++) begin
            wr(OFF_SETA, 8'(i), 0);
            wr(OFF_QSB, 8'(3 - i), 0);
            for (int s = 0; s < 2; s++) begin
                pins(1, 1, s[0]);
                check_fields();
            end
        end
        $display("test band codes done");
        // random legal ratios through register port and loader, back to back
        for (int k = 0; k < 8; k++) begin
            prog_ratio(k[0]);
            wr(8'h31, 8'($urandom), 0);
            check_fields();
            check_reg(OFF_RMQ);
            check_reg(8'h31);
        end
        $display("test loop words done");
        // load capacitance clamps at its ceiling
        for (int d = 0; d < 32; d++) begin
            wr(OFF_XCAP, 8'(d), d[0]);
            check_reg(OFF_XCAP);
            check_fields();
        end
        $display("test load capacitance done");
        // post-divider counts, zero standby, boundary value
        ticks(1, 20, 20);
        ticks(3, 30, 10);
        ticks(0, 40, 0);
        ticks(127, 254, 2);
        check_reg(OFF_PDIV);
        $display("test post-divider done");
        // power-up gating, both supply orders
        pins(1, 0, 0);
        pins(0, 1, 0);
        ticks(3, 30, 0);
        pins(1, 1, 0);
        ticks(3, 30, 10);
        $display("test power gating done");
        // a second reset in mid-run restores every byte
        wr(OFF_FBH, 8'hA5, 0);
        do_reset();
        for (int a = 8'h26; a <= 8'h30; a++) check_reg(8'(a));
        check_fields();
        $display("test second reset done");
        print_verdict();
    end
endmodule
